// >>> src/ebp_top.sv
// What this block does
// RQ1 - Period lasts (period register plus one) times four Tosc times prescale.
// RQ2 - On period match: clear timer, set output, load duty shadow.
// RQ3 - Zero duty leaves the output unset at period start.
// RQ4 - Timer postscaler plays no part in period or frequency.
// RQ5 - Duty is ten bits: duty low byte plus control bits 5:4.
// RQ6 - Duty writes allowed anytime, applied only at next period match.
// RQ7 - Duty shadow register is read-only to software.
// RQ8 - Output clears when shadow duty equals timer with two fine bits.
// RQ9 - Duty longer than period leaves output set all period.
// RQ10 - Prescale of 1, 4 or 16 from timer control bits 1:0.
// RQ11 - Two-bit output configuration picks single, half, forward or reverse.
// RQ12 - Codes 00 single, 10 half, 01 forward, 11 reverse; bit 7 direction.
// RQ13 - Dead band equals four Tosc times seven-bit delay count.
// RQ14 - Half bridge: PWM on output A, complement on output B.
// RQ15 - Outputs go active after delay; too long delay keeps output inactive.
// RQ16 - Alternate pin select at zero moves B, and C in full bridge.
// RQ17 - Full bridge uses four outputs, only two active at once.
// RQ18 - Forward: A held active, D modulated.
// RQ19 - Reverse: C held active, B modulated.
// RQ20 - Direction bit may be written anytime; takes effect next cycle.
// RQ21 - Direction change: blank modulated outputs, swap steady ones 4 times prescale early.
// RQ22 - Full bridge inserts no dead band.
// RQ23 - Software should lower duty before reversing near full duty.
// RQ24 - Configuration at control bits 7:6, mode and polarity bits 3:0.
// RQ25 - Controls load at period boundary; dead band at duty or period.
// RQ26 - Waveforms start only after timer reset.
`timescale 1ns/10ps
module ebp_top import ebp_pkg::*; (
  input wire logic sys_clk, // System clock, 100 MHz
  input wire logic nrst, // Async reset, active low
  input wire logic [31:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [31:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic out_a, // Bridge output A
  output logic out_b, // Bridge output B, default pin
  output logic out_c, // Bridge output C, default pin
  output logic out_d, // Bridge output D
  output logic out_b_alt, // Output B, alternate pin
  output logic out_c_alt // Output C, alternate pin
);
  import ebp_pkg::*;

  logic aw_full_ff, w_full_ff, awready_ff, wready_ff, bvalid_ff;
  logic [31:0] awaddr_ff, wdata_ff;
  logic wstrb0_ff;
  logic [1:0] bresp_ff;
  logic arready_ff, rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic nxt_aw_full, nxt_w_full, nxt_rvalid, do_write, aw_take, w_take, ar_take;
  logic [7:0] ctrl_ff, per_ff, dlow_ff, tctl_ff, db_ff;
  logic alt_ff;
  logic [9:0] duty_sh_ff;
  logic [1:0] cfg_sh_ff;
  logic [3:0] mode_sh_ff;
  logic [6:0] db_sh_ff;
  logic dir_ff, blank_ff, running_ff, pwm_ff;
  logic pwm_en, full_sh, match, dir_chg;
  logic pwm_lvl;
  logic db_a, db_b;
  logic a_act, b_act, c_act, d_act;
  logic nxt_a, nxt_b, nxt_c, nxt_d, nxt_b_alt, nxt_c_alt;
  logic a_ff, b_ff, c_ff, d_ff, b_alt_ff, c_alt_ff;
  logic [31:0] rd_mux;

  ebp_tick_if tk ();

  ebp_timebase u_timebase (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .en(tctl_ff[TON_BIT]),
    .presc(tctl_ff[PS_MSB:0]), // see RQ10
    .period(per_ff),
    .tk(tk.src)
  );

  ebp_deadband #(.CW(7)) u_db_a (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .din(pwm_lvl),
    .count(db_sh_ff),
    .dout(db_a)
  );

  ebp_deadband #(.CW(7)) u_db_b (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .din(!pwm_lvl),
    .count(db_sh_ff),
    .dout(db_b)
  );

  // Bus slave: address and data are taken in either order, answered once both are held
  assign aw_take = s_axi_awvalid && awready_ff;
  assign w_take = s_axi_wvalid && wready_ff;
  assign do_write = aw_full_ff && w_full_ff && !bvalid_ff;
  assign nxt_aw_full = aw_take || (aw_full_ff && !do_write);
  assign nxt_w_full = w_take || (w_full_ff && !do_write);
  assign ar_take = s_axi_arvalid && arready_ff;
  assign nxt_rvalid = rvalid_ff ? !s_axi_rready : ar_take;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
    end else begin
      aw_full_ff <= nxt_aw_full;
      w_full_ff <= nxt_w_full;
      awready_ff <= !nxt_aw_full;
      wready_ff <= !nxt_w_full;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      awaddr_ff <= 32'h0000_0000;
      wdata_ff <= 32'h0000_0000;
      wstrb0_ff <= 1'b0;
    end else begin
      if (aw_take) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_ff <= s_axi_wdata;
        wstrb0_ff <= s_axi_wstrb[0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OK;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= ebp_hit(awaddr_ff) ? RESP_OK : RESP_ERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Software copies; duty, configuration, polarity and dead band reach the logic through shadows, the others directly
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff <= CTRL_RST;
      per_ff <= PER_RST;
      dlow_ff <= DLOW_RST;
      tctl_ff <= TCTL_RST;
      db_ff <= DB_RST;
      alt_ff <= ALT_RST;
    end else if (do_write && wstrb0_ff && ebp_hit(awaddr_ff)) begin
      unique case (awaddr_ff[DEC_W-1:0])
        OFF_CTRL: ctrl_ff <= wdata_ff[7:0]; // see RQ24
        OFF_PER: per_ff <= wdata_ff[7:0];
        OFF_DLOW: dlow_ff <= wdata_ff[7:0]; // see RQ6
        OFF_TCTL: tctl_ff <= wdata_ff[7:0];
        OFF_DB: db_ff <= wdata_ff[7:0];
        OFF_CFG: alt_ff <= wdata_ff[ALT_BIT];
        default: ; // Shadow and status are read-only, see RQ7
      endcase
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (s_axi_araddr[DEC_W-1:0])
      OFF_CTRL: rd_mux[7:0] = ctrl_ff;
      OFF_PER: rd_mux[7:0] = per_ff;
      OFF_DLOW: rd_mux[7:0] = dlow_ff;
      OFF_SHAD: rd_mux[7:0] = duty_sh_ff[9:2];
      OFF_TCTL: rd_mux[7:0] = tctl_ff;
      OFF_DB: rd_mux[7:0] = db_ff;
      OFF_CFG: rd_mux[ALT_BIT] = alt_ff;
      OFF_STAT: rd_mux[11:0] = {blank_ff, dir_ff, running_ff, pwm_ff, tk.timer};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OK;
    end else begin
      arready_ff <= !nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      if (ar_take) begin
        rdata_ff <= ebp_hit(s_axi_araddr) ? rd_mux : 32'h0000_0000;
        rresp_ff <= ebp_hit(s_axi_araddr) ? RESP_OK : RESP_ERR;
      end
    end
  end

  // PWM core
  assign pwm_en = (ctrl_ff[MODE_MSB:MODE_LSB] == MODE_PWM) && tctl_ff[TON_BIT];
  assign full_sh = cfg_sh_ff[0]; // see RQ12
  assign match = tk.step && ({tk.timer, tk.sub} == duty_sh_ff); // see RQ8
  // Level drops in the matching slot itself, so high time is duty slots, not one more
  assign pwm_lvl = pwm_ff && !match; // see RQ8
  assign dir_chg = running_ff && full_sh && tk.last && (ctrl_ff[DIR_BIT] != dir_ff);

  // Output waits for the first timer reset after enabling
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      running_ff <= 1'b0;
    end else if (!pwm_en) begin
      running_ff <= 1'b0;
    end else if (tk.pstart) begin
      running_ff <= 1'b1; // see RQ26
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      duty_sh_ff <= 10'h000;
      cfg_sh_ff <= CFG_SINGLE;
      mode_sh_ff <= 4'h0;
    end else if (tk.pstart) begin
      duty_sh_ff <= {dlow_ff, ctrl_ff[DLSB_MSB:DLSB_LSB]}; // see RQ2 see RQ5 see RQ6
      cfg_sh_ff <= {ctrl_ff[DIR_BIT], ctrl_ff[FULL_BIT]}; // see RQ11 see RQ25
      mode_sh_ff <= ctrl_ff[3:0];
    end
  end

  // Dead band is picked up at whichever boundary comes first
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      db_sh_ff <= 7'h00;
    end else if (tk.pstart || match) begin
      db_sh_ff <= db_ff[DBC_MSB:0]; // see RQ25
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pwm_ff <= 1'b0;
    end else if (!pwm_en) begin
      pwm_ff <= 1'b0;
    end else if (tk.pstart) begin
      pwm_ff <= ({dlow_ff, ctrl_ff[DLSB_MSB:DLSB_LSB]} != 10'h000); // see RQ2 see RQ3
    end else if (match) begin
      pwm_ff <= 1'b0; // see RQ8 see RQ9
    end
  end

  // Steady outputs swap one timer count early; a write during the last count swaps at once
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dir_ff <= 1'b0;
      blank_ff <= 1'b0;
    end else if (dir_chg) begin
      dir_ff <= ctrl_ff[DIR_BIT]; // see RQ20 see RQ21
      blank_ff <= 1'b1;
    end else if (tk.pstart) begin
      blank_ff <= 1'b0;
      if (!(full_sh && ctrl_ff[FULL_BIT])) begin
        dir_ff <= ctrl_ff[DIR_BIT];
      end
    end
  end

  always_comb begin
    a_act = 1'b0;
    b_act = 1'b0;
    c_act = 1'b0;
    d_act = 1'b0;
    if (running_ff) begin
      if (!full_sh) begin
        if (cfg_sh_ff[1]) begin
          a_act = db_a; // see RQ14 see RQ15
          b_act = db_b;
        end else begin
          a_act = pwm_lvl;
        end
      end else if (!dir_ff) begin
        a_act = 1'b1; // see RQ18 see RQ17
        d_act = pwm_lvl && !blank_ff; // see RQ22
      end else begin
        c_act = 1'b1; // see RQ19
        b_act = pwm_lvl && !blank_ff; // see RQ21
      end
    end
  end

  // Unused pins stay low; used pins idle at their inactive level
  always_comb begin
    nxt_a = running_ff && (a_act ^ mode_sh_ff[POL_AC_BIT]);
    nxt_d = running_ff && full_sh && (d_act ^ mode_sh_ff[POL_BD_BIT]);
    nxt_b = 1'b0;
    nxt_b_alt = 1'b0;
    nxt_c = 1'b0;
    nxt_c_alt = 1'b0;
    if (running_ff && cfg_sh_ff != CFG_SINGLE) begin
      if (alt_ff) begin
        nxt_b = b_act ^ mode_sh_ff[POL_BD_BIT];
      end else begin
        nxt_b_alt = b_act ^ mode_sh_ff[POL_BD_BIT]; // see RQ16
      end
    end
    if (running_ff && full_sh) begin
      if (alt_ff) begin
        nxt_c = c_act ^ mode_sh_ff[POL_AC_BIT];
      end else begin
        nxt_c_alt = c_act ^ mode_sh_ff[POL_AC_BIT]; // see RQ16
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      a_ff <= 1'b0;
      b_ff <= 1'b0;
      c_ff <= 1'b0;
      d_ff <= 1'b0;
      b_alt_ff <= 1'b0;
      c_alt_ff <= 1'b0;
    end else begin
      a_ff <= nxt_a;
      b_ff <= nxt_b;
      c_ff <= nxt_c;
      d_ff <= nxt_d;
      b_alt_ff <= nxt_b_alt;
      c_alt_ff <= nxt_c_alt;
    end
  end

  assign out_a = a_ff;
  assign out_b = b_ff;
  assign out_c = c_ff;
  assign out_d = d_ff;
  assign out_b_alt = b_alt_ff;
  assign out_c_alt = c_alt_ff;
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // Period length check helper
  logic [13:0] plen_ff, plen_exp;
  logic plen_ok_ff;
  assign plen_exp = ((14'(per_ff) + 14'h1) << (tctl_ff[1] ? 6 : tctl_ff[0] ? 4 : 2)) - 14'h1;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      plen_ff <= 14'h0;
      plen_ok_ff <= 1'b0;
    end else begin
      plen_ff <= tk.pstart ? 14'h0 : plen_ff + 14'h1;
      if (do_write && (awaddr_ff[DEC_W-1:0] == OFF_PER || awaddr_ff[DEC_W-1:0] == OFF_TCTL)) begin
        plen_ok_ff <= 1'b0;
      end else if (tk.pstart) begin
        plen_ok_ff <= tctl_ff[TON_BIT];
      end
    end
  end

  AST_PERIOD_LEN: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ1
    (tk.pstart && plen_ok_ff) |-> plen_ff == plen_exp) else $error("period length wrong");
  AST_TIMER_CLEAR: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ2
    tk.pstart |=> tk.timer == 8'h00) else $error("timer not cleared at period end");
  AST_DUTY_LOAD: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ6
    tk.pstart |=> duty_sh_ff == {$past(dlow_ff), $past(ctrl_ff[5:4])}) else $error("duty not loaded");
  AST_DUTY_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ7
    !tk.pstart |=> $stable(duty_sh_ff)) else $error("duty shadow changed mid period");
  AST_ZERO_DUTY: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ3
    (tk.pstart && dlow_ff == 8'h00 && ctrl_ff[5:4] == 2'b00) |=> !pwm_ff) else $error("zero duty set output");
  AST_DUTY_CLEAR: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ8
    (match && !tk.pstart) |=> !pwm_ff) else $error("output not cleared at duty match");
  AST_FWD_OUT: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ18
    (running_ff && full_sh && !dir_ff && mode_sh_ff[1:0] == 2'b00) |=> out_a && !out_b && !out_c && !out_b_alt)
    else $error("forward outputs wrong");
  AST_REV_OUT: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ19
    (running_ff && full_sh && dir_ff && alt_ff && mode_sh_ff[1:0] == 2'b00) |=> out_c && !out_a && !out_d)
    else $error("reverse outputs wrong");
  AST_BLANK: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ21
    (blank_ff && mode_sh_ff[1:0] == 2'b00) |=> !out_b && !out_d && !out_b_alt) else $error("blank not honoured");
  AST_HALF_GAP: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ15
    (running_ff && cfg_sh_ff == CFG_HALF) |-> !(a_act && b_act)) else $error("half bridge overlap");
endmodule : ebp_top

// >>> src/ebp_pkg.sv
package ebp_pkg;
  // Register byte offsets
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_PER = 6'h04;
  localparam logic [5:0] OFF_DLOW = 6'h08;
  localparam logic [5:0] OFF_SHAD = 6'h0c;
  localparam logic [5:0] OFF_TCTL = 6'h10;
  localparam logic [5:0] OFF_DB = 6'h14;
  localparam logic [5:0] OFF_CFG = 6'h18;
  localparam logic [5:0] OFF_STAT = 6'h1c;
  localparam int DEC_W = 6;
  // Field positions
  localparam int DIR_BIT = 7;
  localparam int FULL_BIT = 6;
  localparam int DLSB_MSB = 5;
  localparam int DLSB_LSB = 4;
  localparam int MODE_MSB = 3;
  localparam int MODE_LSB = 2;
  localparam int POL_AC_BIT = 1;
  localparam int POL_BD_BIT = 0;
  localparam int PS_MSB = 1;
  localparam int TON_BIT = 2;
  localparam int DBC_MSB = 6;
  localparam int ALT_BIT = 0;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PER_RST = 8'hff;
  localparam logic [7:0] DLOW_RST = 8'h00;
  localparam logic [7:0] TCTL_RST = 8'h00;
  localparam logic [7:0] DB_RST = 8'h00;
  localparam logic ALT_RST = 1'b1;
  // Encodings
  localparam logic [1:0] MODE_PWM = 2'b11;
  localparam logic [1:0] CFG_SINGLE = 2'b00;
  localparam logic [1:0] CFG_HALF = 2'b10;
  localparam logic [1:0] CFG_FWD = 2'b01;
  localparam logic [1:0] CFG_REV = 2'b11;
  localparam logic [1:0] PS_1 = 2'b00;
  localparam logic [1:0] PS_4 = 2'b01;
  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;
  // Timing: one oscillator period is one clock
  localparam int TOSC_NS = 10;
  localparam int CLK_NS = 10;
  localparam int TOSC_PER_TCY = 4;
  localparam int CLK_PER_TOSC = (TOSC_NS + CLK_NS - 1) / CLK_NS;
  localparam int CLK_PER_TCY = TOSC_PER_TCY * CLK_PER_TOSC;

  function automatic logic ebp_hit(input logic [31:0] a);
    return (a[31:DEC_W] == '0) && (a[1:0] == 2'b00);
  endfunction : ebp_hit
endpackage : ebp_pkg

// >>> src/ebp_tick_if.sv
`timescale 1ns/10ps
interface ebp_tick_if;
  logic [7:0] timer;
  logic [1:0] sub;
  logic step;
  logic pstart;
  logic last;
  modport src (output timer, sub, step, pstart, last);
  modport dst (input timer, sub, step, pstart, last);
endinterface : ebp_tick_if

// >>> src/ebp_timebase.sv
`timescale 1ns/10ps
module ebp_timebase import ebp_pkg::*; (
  input wire logic sys_clk, // System clock
  input wire logic nrst, // Async reset
  input wire logic en, // Timer running
  input wire logic [1:0] presc, // Prescale select
  input wire logic [7:0] period, // Period register
  ebp_tick_if.src tk // Timing strobes
);
  logic [5:0] fine_ff;
  logic [7:0] timer_ff;
  logic [5:0] lim;
  logic wrap;

  if (CLK_PER_TOSC != 1) begin : g_chk
    $error("ebp_timebase needs one clock per oscillator period");
  end

  always_comb begin
    unique case (presc)
      PS_1: lim = 6'h03;
      PS_4: lim = 6'h0f;
      default: lim = 6'h3f;
    endcase
  end
  assign wrap = en && (fine_ff == lim);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fine_ff <= 6'h00;
    end else if (!en || wrap) begin
      fine_ff <= 6'h00;
    end else begin
      fine_ff <= fine_ff + 6'h01;
    end
  end

  // Postscaler never reaches this counter
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      timer_ff <= 8'h00;
    end else if (!en) begin
      timer_ff <= 8'h00;
    end else if (wrap) begin
      timer_ff <= (timer_ff == period) ? 8'h00 : timer_ff + 8'h01; // see RQ1 see RQ4
    end
  end

  assign tk.timer = timer_ff;
  assign tk.sub = (presc == PS_1) ? fine_ff[1:0] : (presc == PS_4) ? fine_ff[3:2] : fine_ff[5:4]; // see RQ8
  assign tk.step = en && ((presc == PS_1) || ((presc == PS_4) ? fine_ff[1:0] == 2'b00 : fine_ff[3:0] == 4'h0));
  assign tk.pstart = wrap && (timer_ff == period);
  assign tk.last = en && (timer_ff == period);
endmodule : ebp_timebase

// >>> src/ebp_deadband.sv
`timescale 1ns/10ps
module ebp_deadband import ebp_pkg::*; #(
  parameter int CW = 7
) (
  input wire logic sys_clk, // System clock
  input wire logic nrst, // Async reset
  input wire logic din, // Undelayed drive request
  input wire logic [CW-1:0] count, // Delay in instruction cycles
  output logic dout // Delayed rising edge
);
  logic [CW-1:0] cnt_ff;
  logic [1:0] q_ff;

  if (CW < 1 || CW > 16) begin : g_chk
    $error("ebp_deadband width out of range");
  end

  // Only the rising edge is delayed; a falling request cuts the output at once
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q_ff <= 2'b00;
      cnt_ff <= '0;
    end else if (!din) begin
      q_ff <= 2'b00;
      cnt_ff <= '0;
    end else if (cnt_ff != count) begin
      q_ff <= q_ff + 2'b01;
      if (q_ff == 2'(CLK_PER_TCY - 1)) begin
        cnt_ff <= cnt_ff + 1'b1; // see RQ13
      end
    end
  end
  assign dout = din && (cnt_ff == count); // see RQ15
endmodule : ebp_deadband

// >>> test/ebp_drv_model.sv
`timescale 1ns/10ps
module ebp_drv_model (
  input wire logic sys_clk, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic clr, // Restart on-time counts
  input wire logic [5:0] gate, // Gates: a, b, c, d, b alt, c alt
  output logic [5:0][15:0] on_ff, // Cycles each gate was driven on
  output logic shoot_ff // Both switches of one leg were on together
);
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      on_ff <= '0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        on_ff[i] <= clr ? 16'h0000 : on_ff[i] + {15'h0000, gate[i]};
      end
    end
  end
  // Sticky, so a one-cycle overlap anywhere in the run is not lost
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      shoot_ff <= 1'b0;
    end else begin
      shoot_ff <= shoot_ff | (gate[0] & (gate[1] | gate[4])) | ((gate[2] | gate[5]) & gate[3]);
    end
  end
endmodule : ebp_drv_model

// >>> test/ebp_tb_top.sv
`timescale 1ns/10ps
module ebp_tb_top import ebp_pkg::*;;
  localparam logic [5:0] RADR [6] = '{OFF_CTRL, OFF_PER, OFF_DLOW, OFF_TCTL, OFF_DB, OFF_CFG};
  localparam logic [7:0] RRST [6] = '{CTRL_RST, PER_RST, DLOW_RST, TCTL_RST, DB_RST, 8'h01};
  localparam logic [7:0] MCTL [7] = '{8'h8c, 8'h8c, 8'h8c, 8'h4c, 8'hcc, 8'hcc, 8'h4c};
  localparam logic [7:0] MCFG [7] = '{8'h01, 8'h01, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00};
  localparam logic [7:0] MDB [7] = '{8'h01, 8'h05, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01};
  // Expected on-cycles over four 32-cycle periods with duty 16: a, b, c, d, b alt, c alt
  localparam logic [15:0] MEXP [7][6] = '{'{48, 48, 0, 0, 0, 0}, '{0, 0, 0, 0, 0, 0}, '{48, 0, 0, 0, 48, 0},
    '{128, 0, 0, 64, 0, 0}, '{0, 64, 128, 0, 0, 0}, '{0, 0, 0, 0, 64, 128}, '{128, 0, 0, 64, 0, 0}};
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, clr = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, shoot;
  logic out_a, out_b, out_c, out_d, out_b_alt, out_c_alt;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic [5:0][15:0] cnt;
  int mismatches = 0;
  int n_checks = 0;

  ebp_top DUT (.sys_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .out_a, .out_b, .out_c, .out_d,
    .out_b_alt, .out_c_alt);
  ebp_drv_model drv (.sys_clk, .nrst, .clr, .gate({out_c_alt, out_b_alt, out_d, out_c, out_b, out_a}),
    .on_ff(cnt), .shoot_ff(shoot));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  // Address and data go out together; each is dropped once its own ready is seen
  task automatic axi_wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask : axi_rd

  // Settle w cycles, then count gate on-time over the next w cycles
  task automatic win_chk(input int w, input logic [15:0] e [6]);
    repeat (w) @(posedge sys_clk);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    repeat (w) @(posedge sys_clk);
    #1;
    for (int i = 0; i < 6; i++) begin
      chk($sformatf("gate %0d on-time", i), 32'(e[i]), 32'(cnt[i]));
    end
    chk("leg overlap", 32'h00000000, {31'h00000000, shoot});
  endtask : win_chk

  initial begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      axi_rd({26'h0000000, RADR[i]});
      chk("reset value", {24'h000000, RRST[i]}, rd);
    end
    axi_rd(32'h00000040);
    chk("unmapped resp", {30'h00000000, RESP_ERR}, {30'h00000000, rsp});
    axi_wr(OFF_PER, 8'h03);
    axi_wr(OFF_DLOW, 8'h02);
    axi_wr(OFF_CTRL, 8'h1c);
    for (int p = 0; p < 3; p++) begin
      axi_wr(OFF_TCTL, {5'h00, 1'b1, 2'(p)});
      win_chk(64 << (2 * p), '{16'(36 << (2 * p)), 0, 0, 0, 0, 0});
    end
    axi_wr(OFF_SHAD, 8'h55);
    axi_rd(OFF_SHAD);
    chk("duty shadow", 32'h00000002, rd);
    do begin
      axi_rd(OFF_STAT);
    end while (rd[7:0] !== 8'h00);
    axi_wr(OFF_DLOW, 8'h07);
    axi_rd(OFF_SHAD);
    chk("shadow mid period", 32'h00000002, rd);
    repeat (300) @(posedge sys_clk);
    axi_rd(OFF_SHAD);
    chk("shadow after match", 32'h00000007, rd);
    axi_wr(OFF_TCTL, 8'h04);
    axi_wr(OFF_DLOW, 8'h00);
    axi_wr(OFF_CTRL, 8'h0c);
    win_chk(64, '{0, 0, 0, 0, 0, 0});
    axi_wr(OFF_DLOW, 8'hff);
    win_chk(64, '{64, 0, 0, 0, 0, 0});
    axi_wr(OFF_PER, 8'h07);
    axi_wr(OFF_DLOW, 8'h04);
    for (int r = 0; r < 7; r++) begin
      axi_wr(OFF_CFG, MCFG[r]);
      axi_wr(OFF_DB, MDB[r]);
      axi_wr(OFF_CTRL, MCTL[r]);
      win_chk(128, MEXP[r]);
    end
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    $display("[FAIL] watchdog expected done seen hang");
    end_sim();
  end
endmodule : ebp_tb_top
